// ### core/remappable_pin_select_regs.sv
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// R01 - A five-bit input selector value n from 0 to 25 routes remappable pin n to its peripheral input.
// R02 - The all-ones input selector code ties the peripheral input to ground.
// R03 - An all-zero input selector routes remappable pin 0.
// R04 - At reset input selectors load all ones and output selectors load all zeros.
// R05 - Two-field registers hold the upper field in bits 12..8 and the lower in 4..0, other bits read zero.
// R06 - Single-field registers hold the field in bits 4..0 and bits 15..5 read zero.
// R07 - One register routes the second uart clear-to-send (upper) and receive (lower).
// R08 - One register routes the first spi clock (upper) and data input (lower).
// R09 - One single-field register routes the first spi slave select.
// R10 - One register routes the second spi clock (upper) and data input (lower).
// R11 - One single-field register routes the second spi slave select.
// R12 - One single-field register routes the first can receive, disabled on parts without can.
// R13 - Output selector fields hold a function number that drives remappable pins 0 to 3.
// R14 - Writes touch only implemented bits and a new selection acts on the next clock.
module remappable_pin_select_regs #(
	parameter bit can_present = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [pin_select_pkg::pin_count-1:0] remappable_pin,
	input wire logic [31:0] function_outputs,
	output logic uart_b_rx,
	output logic uart_b_cts,
	output logic spi_a_clock,
	output logic spi_a_datain,
	output logic spi_a_select,
	output logic spi_b_clock,
	output logic spi_b_datain,
	output logic spi_b_select,
	output logic can_a_rx,
	output logic [pin_select_pkg::out_pin_count-1:0] remappable_pin_out,
	output logic [4:0] pin0_output_function,
	output logic [4:0] pin1_output_function,
	output logic [4:0] pin2_output_function,
	output logic [4:0] pin3_output_function
);
	import pin_select_pkg::*;

	// ****************************************
	// synchronisers
	// ****************************************
	logic [pin_count-1:0] pin_meta;
	logic [pin_count-1:0] pin_sync;
	logic [31:0] func_meta;
	logic [31:0] func_sync;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= '0;
			pin_sync <= '0;
			func_meta <= '0;
			func_sync <= '0;
		end else begin
			pin_meta <= remappable_pin;
			pin_sync <= pin_meta;
			func_meta <= function_outputs;
			func_sync <= func_meta;
		end
	end

	// ****************************************
	// selector fields
	// ****************************************
	logic [4:0] uart_b_cts_pin_field;
	logic [4:0] uart_b_rx_pin_field;
	logic [4:0] spi_a_clock_pin_field;
	logic [4:0] spi_a_datain_pin_field;
	logic [4:0] spi_a_select_pin_field;
	logic [4:0] spi_b_clock_pin_field;
	logic [4:0] spi_b_datain_pin_field;
	logic [4:0] spi_b_select_pin_field;
	logic [4:0] can_a_rx_pin_field;
	logic wr_en;
	logic [4:0] wr_hi;
	logic [4:0] wr_lo;
	assign wr_en = psel && penable && pwrite;
	assign wr_hi = pwdata[upper_lsb+field_width-1:upper_lsb];
	assign wr_lo = pwdata[lower_lsb+field_width-1:lower_lsb];

	// only implemented field bits are stored; the rest is dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uart_b_cts_pin_field <= input_reset; // see R04
			uart_b_rx_pin_field <= input_reset;
			spi_a_clock_pin_field <= input_reset;
			spi_a_datain_pin_field <= input_reset;
			spi_a_select_pin_field <= input_reset;
			spi_b_clock_pin_field <= input_reset;
			spi_b_datain_pin_field <= input_reset;
			spi_b_select_pin_field <= input_reset;
			can_a_rx_pin_field <= input_reset;
			pin0_output_function <= output_reset; // see R04
			pin1_output_function <= output_reset;
			pin2_output_function <= output_reset;
			pin3_output_function <= output_reset;
		end else if (wr_en) begin
			if (paddr == uart2_input_select_off) begin
				uart_b_cts_pin_field <= wr_hi; // see R07
				uart_b_rx_pin_field <= wr_lo; // see R14
			end else if (paddr == spi1_clock_data_input_select_off) begin
				spi_a_clock_pin_field <= wr_hi; // see R08
				spi_a_datain_pin_field <= wr_lo;
			end else if (paddr == spi1_slave_select_input_select_off) begin
				spi_a_select_pin_field <= wr_lo; // see R09
			end else if (paddr == spi2_clock_data_input_select_off) begin
				spi_b_clock_pin_field <= wr_hi; // see R10
				spi_b_datain_pin_field <= wr_lo;
			end else if (paddr == spi2_slave_select_input_select_off) begin
				spi_b_select_pin_field <= wr_lo; // see R11
			end else if (paddr == can1_receive_input_select_off) begin
				// disabled register keeps its reset value
				if (can_present) begin
					can_a_rx_pin_field <= wr_lo; // see R12
				end
			end else if (paddr == pins_0_1_output_select_off) begin
				pin1_output_function <= wr_hi; // see R13
				pin0_output_function <= wr_lo;
			end else if (paddr == pins_2_3_output_select_off) begin
				pin3_output_function <= wr_hi;
				pin2_output_function <= wr_lo;
			end
		end
	end

	// ****************************************
	// apb read side
	// ****************************************
	logic [31:0] next_prdata;
	logic next_err;
	always_comb begin
		next_prdata = '0;
		next_err = 1'b0;
		if (paddr == uart2_input_select_off) begin
			next_prdata[12:8] = uart_b_cts_pin_field; // see R05
			next_prdata[4:0] = uart_b_rx_pin_field;
		end else if (paddr == spi1_clock_data_input_select_off) begin
			next_prdata[12:8] = spi_a_clock_pin_field;
			next_prdata[4:0] = spi_a_datain_pin_field;
		end else if (paddr == spi1_slave_select_input_select_off) begin
			next_prdata[4:0] = spi_a_select_pin_field; // see R06
		end else if (paddr == spi2_clock_data_input_select_off) begin
			next_prdata[12:8] = spi_b_clock_pin_field;
			next_prdata[4:0] = spi_b_datain_pin_field;
		end else if (paddr == spi2_slave_select_input_select_off) begin
			next_prdata[4:0] = spi_b_select_pin_field;
		end else if (paddr == can1_receive_input_select_off) begin
			if (can_present) begin
				next_prdata[4:0] = can_a_rx_pin_field;
			end
		end else if (paddr == pins_0_1_output_select_off) begin
			next_prdata[12:8] = pin1_output_function;
			next_prdata[4:0] = pin0_output_function;
		end else if (paddr == pins_2_3_output_select_off) begin
			next_prdata[12:8] = pin3_output_function;
			next_prdata[4:0] = pin2_output_function;
		end else begin
			next_err = 1'b1;
		end
	end

	// one wait state: pready registered so every output is a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			prdata <= pwrite ? 32'h0000_0000 : next_prdata;
			pslverr <= next_err;
		end else begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end
	end

	// ****************************************
	// routing
	// ****************************************
	function automatic logic route(input logic [4:0] sel,
			input logic [pin_count-1:0] pins);
		logic r;
		r = 1'b0;
		// ground code and the unused codes above pin 25 read low
		if (sel <= last_pin_code) begin
			r = pins[sel]; // see R01
		end
		return r;
	endfunction : route

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uart_b_rx <= 1'b0;
			uart_b_cts <= 1'b0;
			spi_a_clock <= 1'b0;
			spi_a_datain <= 1'b0;
			spi_a_select <= 1'b0;
			spi_b_clock <= 1'b0;
			spi_b_datain <= 1'b0;
			spi_b_select <= 1'b0;
			can_a_rx <= 1'b0;
		end else begin
			uart_b_rx <= route(uart_b_rx_pin_field, pin_sync); // see R02
			uart_b_cts <= route(uart_b_cts_pin_field, pin_sync); // see R03
			spi_a_clock <= route(spi_a_clock_pin_field, pin_sync);
			spi_a_datain <= route(spi_a_datain_pin_field, pin_sync);
			spi_a_select <= route(spi_a_select_pin_field, pin_sync);
			spi_b_clock <= route(spi_b_clock_pin_field, pin_sync);
			spi_b_datain <= route(spi_b_datain_pin_field, pin_sync);
			spi_b_select <= route(spi_b_select_pin_field, pin_sync);
			can_a_rx <= can_present && route(can_a_rx_pin_field, pin_sync);
		end
	end

	logic [4:0] out_sel [out_pin_count];
	assign out_sel[0] = pin0_output_function;
	assign out_sel[1] = pin1_output_function;
	assign out_sel[2] = pin2_output_function;
	assign out_sel[3] = pin3_output_function;
	genvar g;
	generate
		for (g = 0; g < out_pin_count; g++) begin : g_out
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					remappable_pin_out[g] <= 1'b0;
				end else begin
					remappable_pin_out[g] <= func_sync[out_sel[g]]; // see R13
				end
			end
		end
	endgenerate

	// ****************************************
	// checks
	// ****************************************
	sequence sel_write_s;
		psel && penable && pwrite && !pready
			&& paddr == spi1_slave_select_input_select_off;
	endsequence
	reset_ground_a: assert property (@(posedge pclk) // see R04
		$rose(presetn) |-> uart_b_rx_pin_field == 5'h1f
			&& pin0_output_function == 5'h00)
		else $error("reset values wrong");
	ground_tie_a: assert property (@(posedge pclk) disable iff (!presetn)
		spi_a_select_pin_field == 5'h1f |=> !spi_a_select) // see R02
		else $error("ground code did not hold input low");
	pin_route_a: assert property (@(posedge pclk) disable iff (!presetn)
		uart_b_cts_pin_field <= 5'h19
		|=> uart_b_cts == $past(pin_sync[uart_b_cts_pin_field])) // see R01
		else $error("pin route wrong");
	pin_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		spi_b_clock_pin_field == 5'h00
		|=> spi_b_clock == $past(pin_sync[0])) // see R03
		else $error("pin zero route wrong");
	field_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		sel_write_s |=> spi_a_select_pin_field == $past(pwdata[4:0])) // see R14
		else $error("write not taken");
	read_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |-> prdata[31:13] == '0 && prdata[7:5] == '0) // see R05
		else $error("unimplemented bits not zero");
	single_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready && !pwrite && paddr == spi2_slave_select_input_select_off
		|-> prdata[15:5] == '0) // see R06
		else $error("single field upper bits not zero");
	ready_one_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("pready timing wrong");
	out_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> remappable_pin_out[2]
			== $past(func_sync[pin2_output_function])) // see R13
		else $error("output pin not driven by function");
	can_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		!can_present |-> can_a_rx_pin_field == 5'h1f) // see R12
		else $error("disabled can selector changed");

	// ****************************************
	// register bus and routing checks
	// ****************************************
	// the access edge is the only edge at which fields may change
	sequence rd_access_s;
		psel && penable && !pwrite && !pready;
	endsequence
	sequence wr_access_s;
		psel && penable && pwrite && !pready;
	endsequence

	uart_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		rd_access_s && paddr == uart2_input_select_off
		|=> prdata == {19'h0, $past(uart_b_cts_pin_field), 3'h0,
			$past(uart_b_rx_pin_field)}) // see R07
		else $error("uart selector read wrong");
	ss_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		rd_access_s && paddr == spi1_slave_select_input_select_off
		|=> prdata == {27'h0, $past(spi_a_select_pin_field)}) // see R09
		else $error("slave select read wrong");
	unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready && paddr == 12'h020
		|=> pslverr && prdata == '0)
		else $error("unmapped access not refused");
	idle_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		!pready |-> prdata == '0 && !pslverr)
		else $error("read data outside access");
	ground_rx_a: assert property (@(posedge pclk) disable iff (!presetn)
		uart_b_rx_pin_field == tie_ground_code |=> !uart_b_rx) // see R02
		else $error("rx ground code not low");
	ground_can_a: assert property (@(posedge pclk) disable iff (!presetn)
		can_a_rx_pin_field == tie_ground_code |=> !can_a_rx) // see R02
		else $error("can ground code not low");
	can_route_a: assert property (@(posedge pclk) disable iff (!presetn)
		can_present && can_a_rx_pin_field <= last_pin_code
		|=> can_a_rx == $past(pin_sync[can_a_rx_pin_field])) // see R12
		else $error("can receive route wrong");
	zero_rx_a: assert property (@(posedge pclk) disable iff (!presetn)
		uart_b_rx_pin_field == 5'h00
		|=> uart_b_rx == $past(pin_sync[0])) // see R03
		else $error("rx pin zero route wrong");
	pair_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_access_s && paddr == spi2_clock_data_input_select_off
		|=> spi_b_clock_pin_field == $past(pwdata[12:8])
			&& spi_b_datain_pin_field == $past(pwdata[4:0])) // see R10
		else $error("two field write wrong");
	out_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_access_s && paddr == pins_2_3_output_select_off
		|=> pin3_output_function == $past(pwdata[12:8])
			&& pin2_output_function == $past(pwdata[4:0])) // see R13
		else $error("output selector write wrong");
	field_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!wr_access_s |=> $stable(spi_a_select_pin_field)) // see R14
		else $error("selector changed without write");
	out_pin0_a: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> remappable_pin_out[0]
			== $past(func_sync[pin0_output_function])) // see R13
		else $error("pin zero output wrong");
	// a read never disturbs the stored selection
	read_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		rd_access_s |=> $stable(pin1_output_function)) // see R14
		else $error("read changed a selector");
endmodule : remappable_pin_select_regs

// ### core/pin_select_pkg.sv
package pin_select_pkg;
	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [11:0] uart2_input_select_off = 12'h000;
	localparam logic [11:0] spi1_clock_data_input_select_off = 12'h004;
	localparam logic [11:0] spi1_slave_select_input_select_off = 12'h008;
	localparam logic [11:0] spi2_clock_data_input_select_off = 12'h00c;
	localparam logic [11:0] spi2_slave_select_input_select_off = 12'h010;
	localparam logic [11:0] can1_receive_input_select_off = 12'h014;
	localparam logic [11:0] pins_0_1_output_select_off = 12'h018;
	localparam logic [11:0] pins_2_3_output_select_off = 12'h01c;
	// ****************************************
	// field layout and codes
	// ****************************************
	localparam int field_width = 5;
	localparam int upper_lsb = 8;
	localparam int lower_lsb = 0;
	localparam int pin_count = 26;
	localparam int out_pin_count = 4;
	localparam logic [4:0] input_reset = 5'h1f;
	localparam logic [4:0] output_reset = 5'h00;
	localparam logic [4:0] tie_ground_code = 5'h1f;
	localparam logic [4:0] last_pin_code = 5'h19;
endpackage : pin_select_pkg

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
	import pin_select_pkg::*;
	// ****************************************
	// signals and design
	// ****************************************
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, function_outputs, rd, d;
	logic [pin_count-1:0] remappable_pin;
	logic [8:0] routed;
	logic [out_pin_count-1:0] remappable_pin_out;
	logic [4:0] ofn_q [4];
	logic [4:0] ofn [4];
	logic [4:0] code [9];
	// implemented bits per word; input words reset to these, outputs to 0
	logic [31:0] mask [8] = '{32'h1f1f, 32'h1f1f, 32'h1f, 32'h1f1f,
		32'h1f, 32'h1f, 32'h1f1f, 32'h1f1f};
	int error_cnt, comparisons;
	remappable_pin_select_regs i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .remappable_pin(remappable_pin),
		.function_outputs(function_outputs), .uart_b_cts(routed[0]),
		.uart_b_rx(routed[1]), .spi_a_clock(routed[2]),
		.spi_a_datain(routed[3]), .spi_a_select(routed[4]),
		.spi_b_clock(routed[5]), .spi_b_datain(routed[6]),
		.spi_b_select(routed[7]), .can_a_rx(routed[8]),
		.remappable_pin_out(remappable_pin_out),
		.pin0_output_function(ofn_q[0]), .pin1_output_function(ofn_q[1]),
		.pin2_output_function(ofn_q[2]), .pin3_output_function(ofn_q[3])
	);
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// ****************************************
	// helpers
	// ****************************************
	task automatic wrap_up();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// one edge passes first so back-to-back calls never drive twice at once
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			error_cnt++;
			wrap_up();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input int idx, input logic [4:0] hi, input logic [4:0] lo);
		apb(1'b1, 12'(idx * 4), {19'h0, hi, 3'h0, lo}, rd, err);
	endtask : wr
	// pin codes past the last pin read as ground, like the all-ones code
	function automatic logic route(input logic [4:0] c,
		input logic [pin_count-1:0] p);
		return (c <= last_pin_code) ? p[c] : 1'b0;
	endfunction : route
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		remappable_pin = '0;
		function_outputs = 32'h0;
		void'($urandom(32'h3690f560));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, 12'(i * 4), 32'h0, rd, err);
			chk(rd, (i < 6) ? mask[i] : 32'h0);
		end
		for (int i = 0; i < 8; i++) begin
			d = $urandom;
			apb(1'b1, 12'(i * 4), d, rd, err);
			chk(err, 0);
			apb(1'b0, 12'(i * 4), 32'h0, rd, err);
			chk(rd, d & mask[i]);
		end
		apb(1'b1, 12'h020, 32'hffffffff, rd, err);
		chk(err, 1);
		apb(1'b0, 12'h020, 32'h0, rd, err);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		// first passes hold the corner codes: pin 0, last pin, ground
		for (int t = 0; t < 24; t++) begin
			for (int k = 0; k < 9; k++)
				code[k] = (t == 0) ? 5'h00 : (t == 1) ? last_pin_code :
					(t == 2) ? tie_ground_code : 5'($urandom_range(0, 31));
			wr(0, code[0], code[1]);
			wr(1, code[2], code[3]);
			wr(2, 5'h0, code[4]);
			wr(3, code[5], code[6]);
			wr(4, 5'h0, code[7]);
			wr(5, 5'h0, code[8]);
			remappable_pin <= pin_count'($urandom);
			repeat (5) @(posedge pclk);
			for (int k = 0; k < 9; k++)
				chk(routed[k], route(code[k], remappable_pin));
		end
		for (int t = 0; t < 16; t++) begin
			for (int k = 0; k < 4; k++)
				ofn[k] = 5'($urandom_range(0, 31));
			wr(6, ofn[1], ofn[0]);
			wr(7, ofn[3], ofn[2]);
			function_outputs <= $urandom;
			repeat (5) @(posedge pclk);
			for (int k = 0; k < 4; k++) begin
				chk(ofn_q[k], ofn[k]);
				chk(remappable_pin_out[k], function_outputs[ofn[k]]);
			end
		end
		wrap_up();
	end
endmodule : tb
